// File: rtl/prefetch_queue_params.svh
// Constants shared by the instruction prefetch queue design files.
`ifndef PREFETCH_QUEUE_PARAMS_SVH
`define PREFETCH_QUEUE_PARAMS_SVH

`define PQ_WORD_W        16
`define PQ_MAX_STAGES    3
`define PQ_OWED_W        4
`define PQ_REFILL_WORDS  4'h3
`define PQ_RESET_ADDR    16'h0000

`define PQ_ST_NONE       2'h0
`define PQ_ST_LATCH      2'h1
`define PQ_ST_ADV_BUS    2'h2
`define PQ_ST_ADV_BUF    2'h3

`define PQ_EX_NONE       2'h0
`define PQ_EX_EVEN       2'h1
`define PQ_EX_ODD        2'h2
`define PQ_EX_FLOW       2'h3

`endif

// File: rtl/prefetch_queue_pkg.sv
// Types shared by the instruction prefetch queue design files.
package prefetch_queue_pkg;

    typedef enum logic [3:0] {
        MV_NONE    = 4'h1,
        MV_LATCH   = 4'h2,
        MV_ADV_BUS = 4'h4,
        MV_ADV_BUF = 4'h8
    } move_e;

endpackage

// File: rtl/queue_move_if.sv
// Movement commands and queue contents passed between control and storage.
`timescale 1ns/1ps
`include "prefetch_queue_params.svh"

interface queue_move_if;
    prefetch_queue_pkg::move_e               mv;
    logic                                    flush;
    logic [`PQ_WORD_W-1:0]                   bus_word;
    logic [`PQ_MAX_STAGES-1:0][`PQ_WORD_W-1:0] stage;
    logic [`PQ_MAX_STAGES-1:0]               stage_v;
    logic [`PQ_WORD_W-1:0]                   buf_word;
    logic                                    buf_full;

    modport ctrl (output mv, flush, bus_word, input stage, stage_v, buf_word, buf_full);
    modport store (input mv, flush, bus_word, output stage, stage_v, buf_word, buf_full);
endinterface

// File: rtl/queue_stage_store.sv
// Queue stages and the holding buffer; index 0 is stage 1.
`timescale 1ns/1ps
`include "prefetch_queue_params.svh"

module queue_stage_store #(
    parameter bit THREE_STAGE = 1'b0
) (
    input  wire logic     clock,
    input  wire logic     arst_n,
    queue_move_if.store   q
);
    localparam int NSTG = THREE_STAGE ? 3 : 2;

    logic advance;
    assign advance = (q.mv == prefetch_queue_pkg::MV_ADV_BUS) ||
                     (q.mv == prefetch_queue_pkg::MV_ADV_BUF);

    genvar i;
    generate
        for (i = 0; i < `PQ_MAX_STAGES; i++) begin : g_stage
            if (i >= NSTG) begin : g_unused
                assign q.stage[i]   = '0;
                assign q.stage_v[i] = 1'b0;
            end else begin : g_live
                logic [`PQ_WORD_W-1:0] word_r;
                logic                  valid_r;
                logic [`PQ_WORD_W-1:0] word_in;
                logic                  valid_in;
                if (i == 0) begin : g_head
                    // New words always enter stage 1, from the bus or the buffer.
                    assign word_in  = (q.mv == prefetch_queue_pkg::MV_ADV_BUS) ?
                                      q.bus_word : q.buf_word;
                    assign valid_in = 1'b1;
                end else begin : g_tail
                    assign word_in  = q.stage[i-1];
                    assign valid_in = q.stage_v[i-1];
                end
                always_ff @(posedge clock or negedge arst_n) begin
                    if (!arst_n) begin
                        word_r  <= '0;
                        valid_r <= 1'b0;
                    end else if (q.flush) begin
                        valid_r <= 1'b0;
                    end else if (advance) begin
                        word_r  <= word_in;
                        valid_r <= valid_in;
                    end
                end
                assign q.stage[i]   = word_r;
                assign q.stage_v[i] = valid_r;
            end
        end

        if (THREE_STAGE) begin : g_no_buffer
            assign q.buf_word = '0;
            assign q.buf_full = 1'b0;
        end else begin : g_buffer
            logic [`PQ_WORD_W-1:0] buf_r;
            logic                  full_r;
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    buf_r  <= '0;
                    full_r <= 1'b0;
                end else if (q.flush) begin
                    full_r <= 1'b0;
                end else if (q.mv == prefetch_queue_pkg::MV_LATCH && !full_r) begin
                    buf_r  <= q.bus_word;
                    full_r <= 1'b1;
                end else if (q.mv == prefetch_queue_pkg::MV_ADV_BUF) begin
                    full_r <= 1'b0;
                end
            end
            assign q.buf_word = buf_r;
            assign q.buf_full = full_r;
        end
    endgenerate
endmodule

// File: rtl/refill_accounting.sv
// Counts owed program word fetches, issues them and tracks stale returns.
`timescale 1ns/1ps
`include "prefetch_queue_params.svh"

module refill_accounting (
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire logic                  flush,
    input  wire logic [15:0]           flow_addr,
    input  wire logic                  done,
    input  wire logic [1:0]            done_words,
    input  wire logic                  bus_gnt,
    input  wire logic                  rx_take,
    output logic                       bus_req,
    output logic [15:0]                bus_addr,
    output logic                       discard,
    output logic [`PQ_OWED_W-1:0]      fetch_owed
);
    logic [`PQ_OWED_W-1:0] owed_r;
    logic [`PQ_OWED_W-1:0] owed_nxt;
    logic [15:0]           fa_r;
    logic [2:0]            outst_r;
    logic [2:0]            stale_r;
    logic                  issued;
    logic [`PQ_OWED_W-1:0] add_words;

    assign bus_req   = (owed_r != '0) && !flush;
    assign issued    = bus_req && bus_gnt;
    assign add_words = done ? {2'h0, done_words} : '0;
    // Each consumed word is replaced by exactly one word fetch.
    assign owed_nxt  = flush ? `PQ_REFILL_WORDS :
                       owed_r + add_words - {3'h0, issued};
    assign bus_addr  = {fa_r[15:1], 1'b0};
    assign discard   = stale_r != 3'h0;
    assign fetch_owed = owed_r;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            owed_r <= `PQ_REFILL_WORDS;
            fa_r   <= `PQ_RESET_ADDR;
        end else begin
            owed_r <= owed_nxt;
            if (flush) begin
                fa_r <= {flow_addr[15:1], 1'b0};
            end else if (issued) begin
                fa_r <= fa_r + 16'h0002;
            end
        end
    end

    // Words already in flight at a change of flow belong to the old path.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            outst_r <= 3'h0;
            stale_r <= 3'h0;
        end else begin
            outst_r <= outst_r + {2'h0, issued} - {2'h0, rx_take};
            if (flush) begin
                stale_r <= outst_r - {2'h0, rx_take};
            end else if (rx_take && discard) begin
                stale_r <= stale_r - 3'h1;
            end
        end
    end
endmodule

// File: rtl/instruction_prefetch_queue.sv
// Instruction prefetch queue: fetch control, queue movement and opcode window.
// Notes on behaviour
// - Refill fetches match words each instruction consumed.
// - Program fetches are whole words, even addresses.
// - Program fetch replaces two bytes, optional one.
// - Optional fetch free when even, fetch when odd.
// - Two status pins multiplex movement and execution.
// - Older variant: two stages plus holding buffer.
// - Words enter stage 1, execute from stage 2.
// - Execution starts with two words queued.
// - Even single-byte instruction does not advance queue.
// - Word arriving when stuck goes to buffer.
// - Newer variant: three stages, in 1, out 3.
// - Every byte selectable; next opcode position predicted. Here the opcode is always one of the two bytes of stage 3.
// - Four movement types compose every queue operation.
// - Busy internal cycles hold all stage contents.
// - Latched buffer word refills stage 1 later.
// - Only first latch before advance writes buffer.
// - Advance from bus loads stage 1 with word.
// - Advance from buffer moves stage 1, loads it from buffer.
// - Latch and buffer advance only in older variant.
// - Instructions execute strictly one at a time.
// - Change of flow refills with three word fetches.
`timescale 1ns/1ps
`include "prefetch_queue_params.svh"

module instruction_prefetch_queue #(
    parameter bit THREE_STAGE = 1'b0
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        instr_done,
    input  wire logic [2:0]  instr_len,
    input  wire logic        busy,
    input  wire logic        flow_change,
    input  wire logic [15:0] flow_addr,
    output logic             op_valid,
    output logic [23:0]      op_bytes,
    output logic [15:0]      instr_pc,
    output logic             bus_req,
    output logic [15:0]      bus_addr,
    input  wire logic        bus_gnt,
    input  wire logic        bus_rvalid,
    input  wire logic [15:0] bus_rdata,
    output logic             bus_rready,
    output logic [1:0]       queue_status_pins
);
    localparam int TOP = THREE_STAGE ? 2 : 1;

    queue_move_if q ();

    logic                  op_valid_r;
    logic                  op_valid_nxt;
    logic [23:0]           op_bytes_r;
    logic [15:0]           pc_r;
    logic                  head_odd_r;
    logic [1:0]            adv_owed_r;
    logic [1:0]            adv_owed_nxt;
    logic [1:0]            status_r;
    logic                  phase_r;
    logic [1:0]            mov_evt_r;
    logic [1:0]            exec_evt_r;

    logic                  take_done;
    logic [3:0]            span;
    logic [1:0]            done_words;
    logic                  discard;
    logic                  rx_take;
    logic                  can_adv;
    logic                  adv_buf_go;
    logic                  top_v;
    logic                  next_v;
    logic                  moved;
    logic [31:0]           window;
    logic [1:0]            mv_code;
    logic [1:0]            start_code;
    logic [`PQ_OWED_W-1:0] fetch_owed;

    // An instruction is only retired while it is the one presented.
    assign take_done  = instr_done && op_valid_r;
    // Words dropped = words spanned from the opcode's half to the end.
    assign span       = {1'b0, instr_len} + {3'h0, head_odd_r};
    assign done_words = span[2:1];

    assign top_v   = q.stage_v[TOP];
    assign next_v  = q.stage_v[TOP-1];
    assign can_adv = !top_v || (adv_owed_r != 2'h0);

    // A full buffer drains first so words never pass each other.
    assign adv_buf_go = !THREE_STAGE && q.buf_full && (adv_owed_r != 2'h0) &&
                        !busy && !flow_change;
    assign bus_rready = !busy && !flow_change && !adv_buf_go &&
                        (discard || can_adv || (!THREE_STAGE && !q.buf_full));
    assign rx_take    = bus_rvalid && bus_rready;

    assign q.flush    = flow_change;
    assign q.bus_word = bus_rdata;
    assign q.mv = adv_buf_go                 ? prefetch_queue_pkg::MV_ADV_BUF :
                  (!rx_take || discard)      ? prefetch_queue_pkg::MV_NONE :
                  can_adv                    ? prefetch_queue_pkg::MV_ADV_BUS :
                                               prefetch_queue_pkg::MV_LATCH;

    assign moved = (q.mv == prefetch_queue_pkg::MV_ADV_BUS) ||
                   (q.mv == prefetch_queue_pkg::MV_ADV_BUF);

    assign adv_owed_nxt = flow_change ? 2'h0 :
                          take_done   ? done_words :
                          (moved && adv_owed_r != 2'h0) ? adv_owed_r - 2'h1 :
                                                          adv_owed_r;

    // Two-word byte window starting at the opcode's word, even byte in the high half.
    assign window       = {q.stage[TOP], q.stage[TOP-1]};
    assign op_valid_nxt = top_v && next_v && (adv_owed_r == 2'h0) &&
                          !moved && !take_done && !flow_change;

    assign mv_code = (q.mv == prefetch_queue_pkg::MV_LATCH)   ? `PQ_ST_LATCH :
                     (q.mv == prefetch_queue_pkg::MV_ADV_BUS) ? `PQ_ST_ADV_BUS :
                     (q.mv == prefetch_queue_pkg::MV_ADV_BUF) ? `PQ_ST_ADV_BUF :
                                                                `PQ_ST_NONE;
    assign start_code = flow_change                  ? `PQ_EX_FLOW :
                        (op_valid_nxt && !op_valid_r) ? (head_odd_r ? `PQ_EX_ODD : `PQ_EX_EVEN) :
                                                        `PQ_EX_NONE;

    queue_stage_store #(
        .THREE_STAGE (THREE_STAGE)
    ) u_store (
        .clock  (clock),
        .arst_n (arst_n),
        .q      (q.store)
    );

    refill_accounting u_acct (
        .clock      (clock),
        .arst_n     (arst_n),
        .flush      (flow_change),
        .flow_addr  (flow_addr),
        .done       (take_done),
        .done_words (done_words),
        .bus_gnt    (bus_gnt),
        .rx_take    (rx_take),
        .bus_req    (bus_req),
        .bus_addr   (bus_addr),
        .discard    (discard),
        .fetch_owed (fetch_owed)
    );

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            op_valid_r <= 1'b0;
            op_bytes_r <= 24'h000000;
            adv_owed_r <= 2'h0;
        end else begin
            op_valid_r <= op_valid_nxt;
            op_bytes_r <= head_odd_r ? window[23:0] : window[31:8];
            adv_owed_r <= adv_owed_nxt;
        end
    end

    // Predicts where the next opcode sits from the current one's length.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pc_r       <= `PQ_RESET_ADDR;
            head_odd_r <= 1'b0;
        end else if (flow_change) begin
            pc_r       <= flow_addr;
            head_odd_r <= flow_addr[0];
        end else if (take_done) begin
            pc_r       <= pc_r + {13'h0000, instr_len};
            head_odd_r <= span[0];
        end
    end

    // Status pins alternate: movement on even phases, execution on odd ones.
    // Events are held until shown, but a newer event arriving before then replaces the held one.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase_r    <= 1'b0;
            mov_evt_r  <= `PQ_ST_NONE;
            exec_evt_r <= `PQ_EX_NONE;
            status_r   <= 2'h0;
        end else begin
            phase_r  <= !phase_r;
            status_r <= phase_r ? exec_evt_r : mov_evt_r;
            if (mv_code != `PQ_ST_NONE) begin
                mov_evt_r <= mv_code;
            end else if (!phase_r) begin
                mov_evt_r <= `PQ_ST_NONE;
            end
            if (start_code != `PQ_EX_NONE) begin
                exec_evt_r <= start_code;
            end else if (phase_r) begin
                exec_evt_r <= `PQ_EX_NONE;
            end
        end
    end

    assign op_valid          = op_valid_r;
    assign op_bytes          = op_bytes_r;
    assign instr_pc          = pc_r;
    assign queue_status_pins = status_r;

    property p_even_fetch;
        @(posedge clock) disable iff (!arst_n)
        bus_req |-> (bus_addr[0] == 1'b0);
    endproperty
    a_even_fetch: assert property (p_even_fetch)
        else $error("program fetch issued at an odd address");

    property p_refill_matches;
        @(posedge clock) disable iff (!arst_n)
        (take_done && !flow_change) |=> (adv_owed_r == $past(done_words));
    endproperty
    a_refill_matches: assert property (p_refill_matches)
        else $error("words owed differ from words consumed");

    property p_optional_fetch;
        @(posedge clock) disable iff (!arst_n)
        (take_done && !flow_change && instr_len == 3'h5) |=>
            (adv_owed_r == ($past(head_odd_r) ? 2'h3 : 2'h2));
    endproperty
    a_optional_fetch: assert property (p_optional_fetch)
        else $error("optional fetch not resolved by alignment");

    property p_even_single_byte;
        @(posedge clock) disable iff (!arst_n)
        (take_done && !flow_change && !head_odd_r && instr_len == 3'h1) |=>
            (adv_owed_r == 2'h0) && head_odd_r && $stable(q.stage[TOP]);
    endproperty
    a_even_single_byte: assert property (p_even_single_byte)
        else $error("queue moved after aligned single-byte instruction");

    property p_busy_hold;
        @(posedge clock) disable iff (!arst_n)
        busy |=> $stable(q.stage);
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("stage contents changed during busy cycle");

    property p_first_latch_only;
        @(posedge clock) disable iff (!arst_n)
        (q.mv == prefetch_queue_pkg::MV_LATCH) |-> !q.buf_full;
    endproperty
    a_first_latch_only: assert property (p_first_latch_only)
        else $error("latch taken while buffer already full");

    property p_bus_load;
        @(posedge clock) disable iff (!arst_n)
        (q.mv == prefetch_queue_pkg::MV_ADV_BUS) |=>
            (q.stage[0] == $past(bus_rdata)) && (q.stage[1] == $past(q.stage[0]));
    endproperty
    a_bus_load: assert property (p_bus_load)
        else $error("advance from bus did not shift and load stage 1");

    property p_buf_load;
        @(posedge clock) disable iff (!arst_n)
        (q.mv == prefetch_queue_pkg::MV_ADV_BUF) |=>
            (q.stage[0] == $past(q.buf_word)) && !q.buf_full;
    endproperty
    a_buf_load: assert property (p_buf_load)
        else $error("advance from buffer did not load stage 1");

    property p_no_buffer_moves;
        @(posedge clock) disable iff (!arst_n)
        THREE_STAGE |-> (q.mv == prefetch_queue_pkg::MV_NONE ||
                         q.mv == prefetch_queue_pkg::MV_ADV_BUS);
    endproperty
    a_no_buffer_moves: assert property (p_no_buffer_moves)
        else $error("buffer movement in the three-stage variant");

    property p_one_at_a_time;
        @(posedge clock) disable iff (!arst_n)
        take_done |=> !op_valid_r;
    endproperty
    a_one_at_a_time: assert property (p_one_at_a_time)
        else $error("next instruction presented in the retiring cycle");

    property p_start_needs_words;
        @(posedge clock) disable iff (!arst_n)
        $rose(op_valid_r) |-> $past(top_v) && $past(next_v) && top_v && next_v;
    endproperty
    a_start_needs_words: assert property (p_start_needs_words)
        else $error("execution began with fewer than two words queued");

    property p_flow_refill;
        @(posedge clock) disable iff (!arst_n)
        flow_change |=> (fetch_owed == `PQ_REFILL_WORDS) && !op_valid_r && !top_v;
    endproperty
    a_flow_refill: assert property (p_flow_refill)
        else $error("change of flow did not start a three-word refill");
endmodule

// File: verification/program_memory_model.sv
// Program memory model that grants word fetches and returns them in order.
`timescale 1ns/1ps

module program_memory_model (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        slow,
    input  wire logic        bus_req,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rready,
    output logic             bus_gnt,
    output logic             bus_rvalid,
    output logic [15:0]      bus_rdata
);
    logic [15:0] pend_a[$];
    int          pend_t[$];
    int          now;
    logic        tick_r;

    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction

    // A slow memory grants every other cycle and answers late, so words pile up.
    assign bus_gnt = !slow || tick_r;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend_a.delete();
            pend_t.delete();
            now = 0;
            tick_r <= 1'b0;
            bus_rvalid <= 1'b0;
            bus_rdata <= 16'h0000;
        end else begin
            now++;
            tick_r <= !tick_r;
            if (bus_rvalid && bus_rready) begin
                void'(pend_a.pop_front());
                void'(pend_t.pop_front());
            end
            if (bus_req && bus_gnt) begin
                pend_a.push_back(bus_addr);
                pend_t.push_back(now);
            end
            if (pend_a.size() > 0 && now - pend_t[0] >= (slow ? 5 : 2)) begin
                bus_rvalid <= 1'b1;
                bus_rdata <= {mem_byte(pend_a[0]), mem_byte(pend_a[0] + 16'h1)};
            end else begin
                bus_rvalid <= 1'b0;
                // Idle data lines wander so that a stale word is never mistaken for a fresh one.
                bus_rdata <= ~bus_rdata;
            end
        end
    end
endmodule

// File: verification/instruction_prefetch_queue_bench.sv
// Self-checking bench for the instruction prefetch queue, both variants.
`timescale 1ns/1ps

module instruction_prefetch_queue_bench;
    logic        clock;
    logic        arst_n;
    logic        instr_done;
    logic [2:0]  instr_len;
    logic        busy;
    logic        flow_change;
    logic [15:0] flow_addr;
    logic        op_valid;
    logic [23:0] op_bytes;
    logic [15:0] instr_pc;
    logic        bus_req;
    logic [15:0] bus_addr;
    logic        bus_gnt;
    logic        bus_rvalid;
    logic [15:0] bus_rdata;
    logic        bus_rready;
    logic [1:0]  queue_status_pins;
    logic        slow;
    logic [7:0]  seen;
    logic [15:0] pc;
    int          n_fail;
    int          check_count;
    int          grants;
    logic        instr_done3;
    logic        op_valid3;
    logic [23:0] op_bytes3;
    logic [15:0] instr_pc3;
    logic        bus_req3;
    logic [15:0] bus_addr3;
    logic        bus_gnt3;
    logic        bus_rvalid3;
    logic [15:0] bus_rdata3;
    logic        bus_rready3;
    logic [1:0]  pins3;
    logic        buf_move3;
    int          cyc;

    instruction_prefetch_queue #(.THREE_STAGE(1'b0)) i_dut (
        .clock, .arst_n, .instr_done, .instr_len, .busy, .flow_change, .flow_addr,
        .op_valid, .op_bytes, .instr_pc, .bus_req, .bus_addr, .bus_gnt, .bus_rvalid,
        .bus_rdata, .bus_rready, .queue_status_pins
    );

    program_memory_model i_mem (
        .clock, .arst_n, .slow, .bus_req, .bus_addr, .bus_rready, .bus_gnt, .bus_rvalid,
        .bus_rdata
    );

    instruction_prefetch_queue #(.THREE_STAGE(1'b1)) i_dut3 (
        .clock, .arst_n, .instr_done(instr_done3), .instr_len, .busy, .flow_change,
        .flow_addr, .op_valid(op_valid3), .op_bytes(op_bytes3), .instr_pc(instr_pc3),
        .bus_req(bus_req3), .bus_addr(bus_addr3), .bus_gnt(bus_gnt3),
        .bus_rvalid(bus_rvalid3), .bus_rdata(bus_rdata3), .bus_rready(bus_rready3),
        .queue_status_pins(pins3)
    );

    program_memory_model i_mem3 (
        .clock, .arst_n, .slow, .bus_req(bus_req3), .bus_addr(bus_addr3),
        .bus_rready(bus_rready3), .bus_gnt(bus_gnt3), .bus_rvalid(bus_rvalid3),
        .bus_rdata(bus_rdata3)
    );

    always #2 clock = ~clock;

    always @(posedge clock) begin
        cyc <= arst_n ? cyc + 1 : 0;
        if (arst_n && bus_req && bus_gnt) begin
            grants <= grants + 1;
            check("fetch address bit 0", 24'h0, {23'h0, bus_addr[0]});
        end
    end

    // Phase zero shows movement, so the phase is known from the edge count.
    always @(negedge clock) begin
        if (arst_n && cyc > 0) seen[{~cyc[0], queue_status_pins}] = 1'b1;
        if (arst_n && cyc[0] && pins3[0]) buf_move3 = 1'b1;
    end

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [23:0] exp_win(input logic [15:0] a);
        return {i_mem.mem_byte(a), i_mem.mem_byte(a + 16'h1), i_mem.mem_byte(a + 16'h2)};
    endfunction

    task automatic settle(input int g0, input int words);
        int i;
        for (i = 0; i < 100 && op_valid !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        check("opcode valid", 24'h1, {23'h0, op_valid});
        check("opcode window", exp_win(pc), op_bytes);
        check("opcode address", {8'h00, pc}, {8'h00, instr_pc});
        repeat (4) @(posedge clock);
        #1;
        check("refill words", 24'(words), 24'(grants - g0));
    endtask

    task automatic retire(input logic [2:0] len, input bit hold);
        int g0;
        int words;
        logic [23:0] w;
        @(posedge clock);
        instr_done <= 1'b1;
        instr_len <= len;
        g0 = grants;
        words = (int'(pc[0]) + int'(len)) >> 1;
        @(posedge clock);
        instr_done <= 1'b0;
        busy <= hold;
        #1;
        check("opcode taken", 24'h0, {23'h0, op_valid});
        if (hold) begin
            repeat (2) @(posedge clock);
            #1;
            w = op_bytes;
            repeat (4) begin
                check("busy return stall", 24'h0, {23'h0, bus_rready});
                @(posedge clock);
                #1;
                check("busy queue hold", w, op_bytes);
            end
            @(posedge clock);
            busy <= 1'b0;
            #1;
        end
        pc = pc + 16'(len);
        settle(g0, words);
    endtask

    task automatic t_lengths();
        logic [2:0] lens [8] = '{3'h1, 3'h3, 3'h3, 3'h2, 3'h6, 3'h5, 3'h1, 3'h4};
        foreach (lens[i]) retire(lens[i], 1'b0);
        $display("test instruction lengths done");
    endtask

    task automatic t_slow();
        @(posedge clock);
        slow <= 1'b1;
        retire(3'h1, 1'b0);
        retire(3'h1, 1'b1);
        retire(3'h3, 1'b0);
        retire(3'h2, 1'b1);
        @(posedge clock);
        slow <= 1'b0;
        $display("test slow memory done");
    endtask

    // An instruction retiring in the flush cycle must be dropped with the old stream.
    task automatic t_flow(input logic [15:0] a);
        int g0;
        @(posedge clock);
        flow_change <= 1'b1;
        flow_addr <= a;
        instr_done <= 1'b1;
        instr_len <= 3'h2;
        g0 = grants;
        @(posedge clock);
        flow_change <= 1'b0;
        instr_done <= 1'b0;
        #1;
        check("flow fetch address", {8'h00, a & 16'hFFFE}, {8'h00, bus_addr});
        check("flow flush", 24'h0, {23'h0, op_valid});
        pc = a;
        settle(g0, 3);
        $display("test change of flow done");
    endtask

    // The newer variant has no buffer, so its movement phases never show codes 1 or 3.
    task automatic t_three();
        int i;
        check("three-stage window", exp_win(pc), op_bytes3);
        @(posedge clock);
        instr_done3 <= 1'b1;
        instr_len <= 3'h3;
        @(posedge clock);
        instr_done3 <= 1'b0;
        for (i = 0; i < 12; i++) begin
            @(posedge clock);
            #1;
        end
        check("three-stage valid", 24'h1, {23'h0, op_valid3});
        check("three-stage window", exp_win(pc + 16'h3), op_bytes3);
        check("three-stage address", {8'h00, pc + 16'h3}, {8'h00, instr_pc3});
        check("three-stage buffer moves", 24'h0, {23'h0, buf_move3});
        $display("test three-stage variant done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        instr_done = 1'b0;
        instr_len = 3'h0;
        busy = 1'b0;
        flow_change = 1'b0;
        flow_addr = 16'h0000;
        slow = 1'b0;
        seen = 8'h00;
        pc = 16'h0000;
        n_fail = 0;
        check_count = 0;
        grants = 0;
        cyc = 0;
        instr_done3 = 1'b0;
        buf_move3 = 1'b0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        settle(0, 3);
        $display("test reset refill done");
        t_lengths();
        t_slow();
        t_flow(16'h1235);
        t_flow(16'h4000);
        t_three();
        check("status codes seen", 24'hEE, {16'h0, seen & 8'hEE});
        $display("test status pins done");
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("watchdog expired");
        final_report();
    end
endmodule
